// *** ofd_pkg.sv ***
// Shared constants, types and register map of the operand field decoder
package ofd_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFD_CTRL = 8'h00;
  localparam logic [7:0] OFD_WORD0 = 8'h04;
  localparam logic [7:0] OFD_WORD1 = 8'h08;
  localparam logic [7:0] OFD_BANK = 8'h0c;
  localparam logic [7:0] OFD_ACC = 8'h10;
  localparam logic [7:0] OFD_RESULT = 8'h14;
  localparam logic [7:0] OFD_STATUS = 8'h18;
  localparam logic [7:0] OFD_FLAGUPD = 8'h1c;
  localparam logic [7:0] OFD_PRODUCT_LOW_BYTE = 8'h20;
  localparam logic [7:0] OFD_PRODUCT_HIGH_BYTE = 8'h24;
  localparam logic [7:0] OFD_TABLE_POINTER = 8'h28;
  localparam logic [7:0] OFD_TBLLAT = 8'h2c;
  localparam logic [7:0] OFD_DEC0 = 8'h30;
  localparam logic [7:0] OFD_DEC1 = 8'h34;
  localparam logic [7:0] OFD_DEC2 = 8'h38;
  localparam logic [7:0] OFD_DEC3 = 8'h3c;
  localparam logic [7:0] OFD_PTR0 = 8'h40;
  localparam logic [7:0] OFD_SHADOW = 8'h50;
  // Bases for the table direction bit (2) and call return bit (9) of the instruction word
  localparam int OFD_CTRL_RET = 4;
  localparam int OFD_CTRL_TWR = 5;
  // Field position of the affect mask in the flag update register
  localparam int OFD_MASK_LSB = 8;
  // Byte-oriented word layout
  localparam int OFD_D_BIT = 9;
  localparam int OFD_A_BIT = 8;
  // Top nibble that marks a second instruction word
  localparam logic [3:0] OFD_WORD2_TAG = 4'hf;
  // Reset values
  localparam logic [3:0] OFD_CTRL_RST = 4'h0;
  localparam logic [7:0] OFD_BYTE_RST = 8'h00;
  localparam logic [4:0] OFD_FLAG_RST = 5'h00;
  // Lowest access-region address that maps to the top bank
  localparam logic [7:0] OFD_ACCESS_SPLIT = 8'h60;

  // Instruction format, chosen by software
  typedef enum logic [3:0] {
    FMT_BYTE, FMT_BIT, FMT_LIT, FMT_MOVE, FMT_BRREL8, FMT_BRREL11,
    FMT_BRABS, FMT_TABLE, FMT_CALL, FMT_LDPTR, FMT_INDEX
  } ofd_fmt_t;

  // Table pointer access modes
  typedef enum logic [1:0] {
    TBL_KEEP, TBL_POSTINC, TBL_POSTDEC, TBL_PREINC
  } ofd_tbl_t;

  // Decoded operand fields handed to execution
  typedef struct packed {
    logic [11:0] data_addr;
    logic [2:0] bit_idx;
    logic dest_file;
    logic acc_bank;
    logic [1:0] ptr_sel;
    logic fast;
    ofd_tbl_t tbl_mode;
    logic nop;
    logic [19:0] literal;
    logic [20:0] branch;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
  } ofd_dec_t;

  // Flags: carry, digit carry, zero, overflow, negative
  typedef struct packed {
    logic negative;
    logic signed_excess_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } ofd_flags_t;
endpackage : ofd_pkg

// *** ofd_tbl_step.sv ***
// Table pointer step unit: access address and pointer after the access
module ofd_tbl_step
  import ofd_pkg::*;
#(
  parameter int PTR_W = 21
)(
  input wire logic [PTR_W-1:0] ptr,
  input wire ofd_pkg::ofd_tbl_t mode,
  output logic [PTR_W-1:0] access_addr,
  output logic [PTR_W-1:0] next_ptr
);
  // One step of the pointer, shared by all three moving modes
  logic [PTR_W-1:0] one;

  // Pointer arithmetic wraps within its own width
  always_comb
  begin
    one = {{(PTR_W-1){1'b0}}, 1'b1};
    access_addr = ptr;
    next_ptr = ptr;
    case (mode)
      TBL_KEEP:
      begin
        next_ptr = ptr;
      end
      TBL_POSTINC:
      begin
        next_ptr = ptr + one;
      end
      TBL_POSTDEC:
      begin
        next_ptr = ptr - one;
      end
      TBL_PREINC:
      begin
        // Pointer moves before the access and the access uses the new one
        access_addr = ptr + one;
        next_ptr = ptr + one;
      end
      default:
      begin
        next_ptr = ptr;
      end
    endcase
  end
endmodule : ofd_tbl_step

// *** ofd_core.sv ***
// Operand field decoder with its core registers, on an AHB-Lite slave
//
// Functional notes
// - a=0 access region, a=1 uses bank
// - Three-bit field picks bit 0 to 7
// - d=0 result to accumulator, d=1 file
// - f is 8-bit address or pointer designator
// - Moves use two 12-bit addresses, no bank
// - Table ops keep, post-inc, post-dec, pre-inc pointer
// - s=1 saves/restores shadows, s=0 leaves them
// - Table pointer is 21 bits into program memory
// - n is relative signed or absolute target
// - Literal is 8, 12 or 20 bits
// - Don't-care bits never change the result
// - Indexed offsets 7 bits, added to pointer
// - Five flags, only affected ones update
// - Product kept as two readable bytes
// - Byte word: opcode, d, a, file address
// - Lone second word executes as no-op
module ofd_core
  import ofd_pkg::*;
#(
  parameter int BANK_W = 4,
  parameter int PTR_W = 21
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output ofd_pkg::ofd_dec_t dec,
  output logic file_wr,
  output logic [11:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic tbl_req,
  output logic tbl_wr,
  output logic [PTR_W-1:0] tbl_addr
);
  import ofd_pkg::*;

  // Bus pipeline state
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_off_q, wr_off_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d;
  // Software-visible core registers
  logic [3:0] ctrl_q, ctrl_d;
  logic [15:0] word0_q, word0_d;
  logic [15:0] word1_q, word1_d;
  logic [BANK_W-1:0] bank_select_reg_q, bank_select_reg_d;
  logic [7:0] accumulator_reg_q, accumulator_reg_d;
  ofd_flags_t flags_q, flags_d;
  logic [7:0] product_low_byte_q, product_low_byte_d;
  logic [7:0] product_high_byte_q, product_high_byte_d;
  logic [PTR_W-1:0] table_pointer_q, table_pointer_d;
  logic [7:0] table_latch_byte_q, table_latch_byte_d;
  logic [11:0] indirect_pointer_q [4];
  logic [11:0] indirect_pointer_d [4];
  // Shadow copies for fast call and return
  logic [7:0] sh_acc_q, sh_acc_d;
  logic [BANK_W-1:0] sh_bank_q, sh_bank_d;
  ofd_flags_t sh_flags_q, sh_flags_d;
  // Decoder and execution outputs
  ofd_dec_t dec_q, dec_d, dec_new;
  logic file_wr_q, file_wr_d;
  logic [11:0] file_wr_addr_q, file_wr_addr_d;
  logic [7:0] file_wr_data_q, file_wr_data_d;
  logic tbl_req_q, tbl_req_d, tbl_wr_q, tbl_wr_d;
  logic [PTR_W-1:0] tbl_addr_q, tbl_addr_d;
  // Table step results
  logic [PTR_W-1:0] tbl_access, tbl_next;
  // Bus decode helpers
  logic addr_ok, rd_take, wr_take;
  logic rd_late_q, rd_late_d; // Read held back one cycle behind a write

  // Offset of a bus address within the register window
  function automatic logic [7:0] reg_off(input logic [31:0] a);
    reg_off = a[7:0];
  endfunction : reg_off

  // Data address from an 8-bit file field, the a bit and the bank
  function automatic logic [11:0] data_addr(input logic [7:0] f,
    input logic a, input logic [BANK_W-1:0] bank);
    logic [11:0] r;
    r = 12'h000;
    if (a)
      r = {{(4-BANK_W){1'b0}}, bank, f};
    else if (f >= OFD_ACCESS_SPLIT)
      r = {4'hf, f};
    else
      r = {4'h0, f};
    data_addr = r;
  endfunction : data_addr

  // Table pointer step unit
  ofd_tbl_step #(
    .PTR_W(PTR_W)
  ) u_step (
    .ptr(table_pointer_q),
    .mode(dec_new.tbl_mode),
    .access_addr(tbl_access),
    .next_ptr(tbl_next)
  );

  // Field decode of the incoming word; only fields of the chosen format
  // carry word bits, the rest stay zero so stray bits cannot leak
  always_comb
  begin
    logic [15:0] w0;
    logic [15:0] w1;
    w0 = hwdata[15:0];
    w1 = word1_q;
    dec_new = '0;
    case (ofd_fmt_t'(ctrl_q))
      FMT_BYTE:
      begin
        // Opcode in 15:10 is not needed here
        dec_new.dest_file = w0[OFD_D_BIT];
        dec_new.acc_bank = w0[OFD_A_BIT];
        dec_new.data_addr = data_addr(w0[7:0], w0[OFD_A_BIT],
          bank_select_reg_q);
      end
      FMT_BIT:
      begin
        dec_new.bit_idx = w0[11:9];
        dec_new.dest_file = 1'b1;
        dec_new.acc_bank = w0[8];
        dec_new.data_addr = data_addr(w0[7:0], w0[8], bank_select_reg_q);
      end
      FMT_LIT:
      begin
        dec_new.literal = {12'h000, w0[7:0]};
      end
      FMT_MOVE:
      begin
        // Full 12-bit addresses, bank select plays no part
        dec_new.src_addr = w0[11:0];
        dec_new.dst_addr = w1[11:0];
      end
      FMT_BRREL8:
      begin
        dec_new.branch = {{13{w0[7]}}, w0[7:0]};
      end
      FMT_BRREL11:
      begin
        dec_new.branch = {{10{w0[10]}}, w0[10:0]};
      end
      FMT_BRABS, FMT_CALL:
      begin
        dec_new.literal = {w1[11:0], w0[7:0]};
        dec_new.branch = {1'b0, w1[11:0], w0[7:0]};
        if (ofd_fmt_t'(ctrl_q) == FMT_CALL)
          dec_new.fast = w0[8];
      end
      FMT_TABLE:
      begin
        dec_new.tbl_mode = ofd_tbl_t'(w0[1:0]);
      end
      FMT_LDPTR:
      begin
        dec_new.ptr_sel = w0[5:4];
        dec_new.literal = {8'h00, w0[3:0], w1[7:0]};
      end
      FMT_INDEX:
      begin
        // Seven-bit offsets ride on the pointer in slot two
        dec_new.ptr_sel = 2'h2;
        dec_new.src_addr = indirect_pointer_q[2] +
          {5'h00, w0[6:0]};
        dec_new.dst_addr = indirect_pointer_q[2] +
          {5'h00, w1[6:0]};
      end
      default:
      begin
        dec_new = '0;
      end
    endcase
    // A second word on its own does nothing
    if (w0[15:12] == OFD_WORD2_TAG)
    begin
      dec_new = '0;
      dec_new.nop = 1'b1;
    end
  end

  // Next state of the bus slave and every core register
  always_comb
  begin
    logic [7:0] roff;
    logic [4:0] mask;
    logic [7:0] fetch;
    roff = reg_off(haddr);
    fetch = rd_late_q ? wr_off_q : roff;
    mask = hwdata[OFD_MASK_LSB+4:OFD_MASK_LSB];
    addr_ok = hsel && hready && htrans[1];
    rd_take = addr_ok && !hwrite;
    wr_take = addr_ok && hwrite;
    wr_pend_d = wr_take;
    wr_off_d = addr_ok ? roff : wr_off_q;
    // A read chasing a write is taken now but fetched a cycle later so
    // it sees the written value; one wait state covers the delay
    rd_late_d = rd_take && wr_pend_q;
    rdy_d = !rd_late_d;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    word0_d = word0_q;
    word1_d = word1_q;
    bank_select_reg_d = bank_select_reg_q;
    accumulator_reg_d = accumulator_reg_q;
    flags_d = flags_q;
    product_low_byte_d = product_low_byte_q;
    product_high_byte_d = product_high_byte_q;
    table_pointer_d = table_pointer_q;
    table_latch_byte_d = table_latch_byte_q;
    indirect_pointer_d = indirect_pointer_q;
    sh_acc_d = sh_acc_q;
    sh_bank_d = sh_bank_q;
    sh_flags_d = sh_flags_q;
    dec_d = dec_q;
    file_wr_d = 1'b0;
    file_wr_addr_d = file_wr_addr_q;
    file_wr_data_d = file_wr_data_q;
    tbl_req_d = 1'b0;
    tbl_wr_d = tbl_wr_q;
    tbl_addr_d = tbl_addr_q;
    // Read data is fetched in the address phase, or a cycle later behind a write, and shown in the data phase
    if ((rd_take && !wr_pend_q) || rd_late_q)
    begin
      case (fetch)
        OFD_CTRL: rdata_d = {28'h0, ctrl_q};
        OFD_WORD0: rdata_d = {16'h0, word0_q};
        OFD_WORD1: rdata_d = {16'h0, word1_q};
        OFD_BANK: rdata_d = {{(32-BANK_W){1'b0}}, bank_select_reg_q};
        OFD_ACC: rdata_d = {24'h0, accumulator_reg_q};
        OFD_STATUS: rdata_d = {27'h0, flags_q};
        OFD_PRODUCT_LOW_BYTE: rdata_d = {24'h0, product_low_byte_q};
        OFD_PRODUCT_HIGH_BYTE: rdata_d = {24'h0, product_high_byte_q};
        OFD_TABLE_POINTER: rdata_d = {{(32-PTR_W){1'b0}}, table_pointer_q};
        OFD_TBLLAT: rdata_d = {24'h0, table_latch_byte_q};
        OFD_DEC0: rdata_d = {9'h0, dec_q.nop, dec_q.tbl_mode, dec_q.fast,
          dec_q.ptr_sel, dec_q.acc_bank, dec_q.dest_file, dec_q.bit_idx,
          dec_q.data_addr};
        OFD_DEC1: rdata_d = {12'h0, dec_q.literal};
        OFD_DEC2: rdata_d = {11'h0, dec_q.branch};
        OFD_DEC3: rdata_d = {4'h0, dec_q.dst_addr, 4'h0, dec_q.src_addr};
        OFD_PTR0, OFD_PTR0 + 8'h04, OFD_PTR0 + 8'h08, OFD_PTR0 + 8'h0c:
          rdata_d = {20'h0, indirect_pointer_q[fetch[3:2]]};
        OFD_SHADOW: rdata_d = {11'h0, sh_flags_q,
          {(8-BANK_W){1'b0}}, sh_bank_q, sh_acc_q};
        default: rdata_d = 32'h0;
      endcase
    end
    // Writes land in the data phase
    if (wr_pend_q)
    begin
      case (wr_off_q)
        OFD_CTRL: ctrl_d = hwdata[3:0];
        OFD_WORD1: word1_d = hwdata[15:0];
        OFD_BANK: bank_select_reg_d = hwdata[BANK_W-1:0];
        OFD_ACC: accumulator_reg_d = hwdata[7:0];
        OFD_PRODUCT_LOW_BYTE: product_low_byte_d = hwdata[7:0];
        OFD_PRODUCT_HIGH_BYTE: product_high_byte_d = hwdata[7:0];
        OFD_TABLE_POINTER: table_pointer_d = hwdata[PTR_W-1:0];
        OFD_TBLLAT: table_latch_byte_d = hwdata[7:0];
        OFD_PTR0, OFD_PTR0 + 8'h04, OFD_PTR0 + 8'h08, OFD_PTR0 + 8'h0c:
          indirect_pointer_d[wr_off_q[3:2]] = hwdata[11:0];
        OFD_FLAGUPD:
        begin
          // Flags outside the mask keep their value
          flags_d = (flags_q & ~mask) | (hwdata[4:0] & mask);
        end
        OFD_RESULT:
        begin
          if (dec_q.dest_file)
          begin
            file_wr_d = 1'b1;
            file_wr_addr_d = dec_q.data_addr;
            file_wr_data_d = hwdata[7:0];
          end
          else
            accumulator_reg_d = hwdata[7:0];
        end
        OFD_WORD0:
        begin
          // Latching the word also latches every decoded field
          word0_d = hwdata[15:0];
          dec_d = dec_new;
          if (!dec_new.nop)
          begin
            case (ofd_fmt_t'(ctrl_q))
              FMT_LDPTR:
                indirect_pointer_d[dec_new.ptr_sel] =
                  dec_new.literal[11:0];
              FMT_TABLE:
              begin
                tbl_req_d = 1'b1;
                // Direction comes from this word only, never the last one
                tbl_wr_d = hwdata[OFD_CTRL_TWR-3];
                tbl_addr_d = tbl_access;
                table_pointer_d = tbl_next;
              end
              FMT_CALL:
              begin
                if (dec_new.fast && !hwdata[OFD_CTRL_RET+5])
                begin
                  sh_acc_d = accumulator_reg_q;
                  sh_bank_d = bank_select_reg_q;
                  sh_flags_d = flags_q;
                end
                else if (dec_new.fast)
                begin
                  accumulator_reg_d = sh_acc_q;
                  bank_select_reg_d = sh_bank_q;
                  flags_d = sh_flags_q;
                end
              end
              default:
              begin
                tbl_req_d = 1'b0;
              end
            endcase
          end
        end
        default:
        begin
          // Unmapped writes are accepted and dropped
          file_wr_d = 1'b0;
        end
      endcase
    end
  end

  // Registers of the whole block
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_off_q <= 8'h00;
      rdata_q <= 32'h0;
      rdy_q <= 1'b1;
      rd_late_q <= 1'b0;
      ctrl_q <= OFD_CTRL_RST;
      word0_q <= 16'h0;
      word1_q <= 16'h0;
      bank_select_reg_q <= '0;
      accumulator_reg_q <= OFD_BYTE_RST;
      flags_q <= OFD_FLAG_RST;
      product_low_byte_q <= OFD_BYTE_RST;
      product_high_byte_q <= OFD_BYTE_RST;
      table_pointer_q <= '0;
      table_latch_byte_q <= OFD_BYTE_RST;
      indirect_pointer_q <= '{default: 12'h000};
      sh_acc_q <= OFD_BYTE_RST;
      sh_bank_q <= '0;
      sh_flags_q <= OFD_FLAG_RST;
      dec_q <= '0;
      file_wr_q <= 1'b0;
      file_wr_addr_q <= 12'h000;
      file_wr_data_q <= OFD_BYTE_RST;
      tbl_req_q <= 1'b0;
      tbl_wr_q <= 1'b0;
      tbl_addr_q <= '0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_off_q <= wr_off_d;
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      rd_late_q <= rd_late_d;
      ctrl_q <= ctrl_d;
      word0_q <= word0_d;
      word1_q <= word1_d;
      bank_select_reg_q <= bank_select_reg_d;
      accumulator_reg_q <= accumulator_reg_d;
      flags_q <= flags_d;
      product_low_byte_q <= product_low_byte_d;
      product_high_byte_q <= product_high_byte_d;
      table_pointer_q <= table_pointer_d;
      table_latch_byte_q <= table_latch_byte_d;
      indirect_pointer_q <= indirect_pointer_d;
      sh_acc_q <= sh_acc_d;
      sh_bank_q <= sh_bank_d;
      sh_flags_q <= sh_flags_d;
      dec_q <= dec_d;
      file_wr_q <= file_wr_d;
      file_wr_addr_q <= file_wr_addr_d;
      file_wr_data_q <= file_wr_data_d;
      tbl_req_q <= tbl_req_d;
      tbl_wr_q <= tbl_wr_d;
      tbl_addr_q <= tbl_addr_d;
    end
  end

  // Outputs come straight from flip-flops; response is always OKAY
  assign hrdata = rdata_q;
  assign hreadyout = rdy_q;
  assign hresp = 1'b0;
  assign dec = dec_q;
  assign file_wr = file_wr_q;
  assign file_wr_addr = file_wr_addr_q;
  assign file_wr_data = file_wr_data_q;
  assign tbl_req = tbl_req_q;
  assign tbl_wr = tbl_wr_q;
  assign tbl_addr = tbl_addr_q;
endmodule : ofd_core

// *** ofd_core_checker.sv ***
// Port checker for the operand field decoder, bound to its top module
module ofd_checker
  import ofd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ofd_pkg::ofd_dec_t dec,
  input wire logic file_wr,
  input wire logic [11:0] file_wr_addr,
  input wire logic tbl_req
);
  import ofd_pkg::*;
  logic wr_d; // Write address phase taken now
  logic w0_d; // Same, aimed at the instruction word
  logic wr_q; // Write in its data phase
  logic w0_q; // Instruction word write in its data phase
  // Spot taken write address phases
  always_comb
  begin
    wr_d = hsel && hready && htrans[1] && hwrite;
    w0_d = wr_d && (haddr[7:0] == OFD_WORD0);
  end
  // One stage is enough: write data phases never stall
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      w0_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
      w0_q <= w0_d;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("Slave answered with an error");
  a_wait_once: assert property (!hreadyout |=> hreadyout)
    else $error("Wait state lasted over one cycle");
  a_wait_cause: assert property (!hreadyout |-> $past(wr_q))
    else $error("Wait state with no write ahead of it");
  a_tbl_pulse: assert property (tbl_req |=> !tbl_req)
    else $error("Table request longer than one cycle");
  a_tbl_cause: assert property (tbl_req |-> $past(w0_q && hready))
    else $error("Table request without an instruction write");
  a_file_pulse: assert property (file_wr |=> !file_wr)
    else $error("File write longer than one cycle");
  a_fwa_hold: assert property (!$stable(file_wr_addr) |-> file_wr)
    else $error("File write address moved without a write");
  a_dec_hold: assert property (!$stable(dec) |-> $past(w0_q && hready))
    else $error("Decoded fields moved without an instruction write");
  a_nop_blank: assert property (dec.nop |-> dec.data_addr == 12'h000
    && dec.branch == 21'h0 && !tbl_req)
    else $error("Lone second word left operands or effects");
  c_tbl: cover property (tbl_req);
  c_file: cover property (file_wr);
  c_nop: cover property (dec.nop);
  c_wait: cover property (!hreadyout);
endmodule : ofd_checker

bind ofd_core ofd_checker chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .dec(dec),
  .file_wr(file_wr), .file_wr_addr(file_wr_addr), .tbl_req(tbl_req));

// *** ofd_far_model.sv ***
// Register file and table memory model on the execution side
module ofd_far_model
  import ofd_pkg::*;
#(
  parameter int PTR_W = 21
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic file_wr,
  input wire logic [11:0] file_wr_addr,
  input wire logic [7:0] file_wr_data,
  input wire logic tbl_req,
  input wire logic tbl_wr,
  input wire logic [PTR_W-1:0] tbl_addr
);
  import ofd_pkg::*;
  logic [7:0] file_mem [4096]; // Whole 12-bit register file space
  logic [PTR_W-1:0] last_tbl; // Last program memory address touched
  int n_tbl_wr; // Table writes seen, for debug
  // Store results and log table traffic; left unknown until written
  always @(posedge hclk)
  begin
    if (hresetn && file_wr)
      file_mem[file_wr_addr] <= file_wr_data;
    if (hresetn && tbl_req)
    begin
      last_tbl <= tbl_addr;
      n_tbl_wr <= n_tbl_wr + int'(tbl_wr);
    end
  end
  initial n_tbl_wr = 0;
endmodule : ofd_far_model

// *** test_operand_field_decoder.sv ***
// Self-checking bench for the operand field decoder
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_operand_field_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import ofd_pkg::*;
  logic hclk = 1'b0; // 40 MHz bus clock
  logic hresetn = 1'b0; // Held low for 8 cycles
  logic hsel = 1'b1; // Only slave on the bus
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // Whole words only
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  ofd_dec_t dec;
  logic file_wr;
  logic [11:0] file_wr_addr;
  logic [7:0] file_wr_data;
  logic tbl_req;
  logic tbl_wr;
  logic [20:0] tbl_addr;
  int n_errors = 0;
  int samples_checked = 0;

  // Free-running bus clock
  always #12.5 hclk = ~hclk;

  ofd_core #(.BANK_W(4), .PTR_W(21)) dut_u (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dec(dec),
    .file_wr(file_wr), .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data), .tbl_req(tbl_req), .tbl_wr(tbl_wr),
    .tbl_addr(tbl_addr));
  ofd_far_model #(.PTR_W(21)) far_u (.hclk(hclk), .hresetn(hresetn),
    .file_wr(file_wr), .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data), .tbl_req(tbl_req), .tbl_wr(tbl_wr),
    .tbl_addr(tbl_addr));

  // Verdict and end of run
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // Wait for hready high at a rising edge; a hang counts as a mismatch
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      n_errors++;
      results();
    end
  endtask : wait_rdy

  // Address phase, held until taken
  task automatic addr_ph(input logic [7:0] a, input logic w);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
  endtask : addr_ph

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    addr_ph(a, 1'b0);
    htrans <= 2'b00;
    wait_rdy();
    q = hrdata;
  endtask : rd

  // Write with a read pipelined behind it; the read meets a wait state
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    addr_ph(a, 1'b1);
    hwdata <= d;
    hwrite <= 1'b0;
    wait_rdy();
    htrans <= 2'b00;
    wait_rdy();
    q = hrdata;
  endtask : wr_rd

  // Issue an instruction word and settle inside the following cycle
  task automatic exec(input logic [15:0] w);
    wr(OFD_WORD0, {16'h0, w});
    @(negedge hclk);
  endtask : exec

  function automatic logic [11:0] exp_addr(input logic a,
    input logic [3:0] bank, input logic [7:0] f);
    if (a)
      return {bank, f};
    return (f < OFD_ACCESS_SPLIT) ? {4'h0, f} : {4'hf, f};
  endfunction : exp_addr

  function automatic logic [20:0] exp_next(input logic [20:0] p,
    input logic [1:0] m);
    return (m == 2'd0) ? p : (m == 2'd2) ? p - 21'd1 : p + 21'd1;
  endfunction : exp_next

  // Main sequence; don't-care bits are random in byte-format opcodes and in the lone second word, fixed patterns elsewhere
  initial
  begin
    logic [31:0] q;
    logic [31:0] q2;
    logic [15:0] w;
    logic [3:0] bank;
    logic [7:0] r;
    logic [11:0] d12;
    logic [20:0] p;
    logic [4:0] fl;
    logic [4:0] m5;
    q = $urandom(27);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK(dec, 88'h0)
    `CHK(hreadyout, 1'b1)
    // Byte format: bank, access region edge, destination
    wr(OFD_CTRL, {28'h0, FMT_BYTE});
    for (int i = 0; i < 12; i++)
    begin
      bank = 4'($urandom);
      w = 16'($urandom);
      w[15:12] = 4'($urandom_range(14, 0));
      r = 8'($urandom);
      if (i < 2)
        w[8:0] = {1'b0, 8'h5f + 8'(i)};
      wr(OFD_BANK, {28'h0, bank});
      exec(w);
      `CHK(dec.data_addr, exp_addr(w[8], bank, w[7:0]))
      `CHK(dec.dest_file, w[9])
      wr(OFD_RESULT, {24'h0, r});
      repeat (3) @(posedge hclk);
      if (w[9])
        `CHK(far_u.file_mem[exp_addr(w[8], bank, w[7:0])], r)
      else
      begin
        rd(OFD_ACC, q);
        `CHK(q[7:0], r)
      end
    end
    // Bit format: every bit position
    wr(OFD_CTRL, {28'h0, FMT_BIT});
    for (int b = 0; b < 8; b++)
    begin
      exec({4'h7, 3'(b), 1'b0, 8'($urandom)});
      `CHK(dec.bit_idx, 3'(b))
    end
    // Lone second word
    exec({4'hf, 12'($urandom)});
    `CHK(dec.nop, 1'b1)
    `CHK(dec.data_addr, 12'h000)
    // Two-word move ignores the bank
    wr(OFD_CTRL, {28'h0, FMT_MOVE});
    d12 = 12'($urandom);
    w = {4'hc, 12'($urandom)};
    wr(OFD_WORD1, {16'h0, 4'hf, d12});
    exec(w);
    `CHK(dec.src_addr, w[11:0])
    `CHK(dec.dst_addr, d12)
    // Table modes, with wrap at both ends of the pointer
    wr(OFD_CTRL, {28'h0, FMT_TABLE});
    for (int m = 0; m < 4; m++)
    begin
      p = (m == 1) ? 21'h1fffff : (m == 2) ? 21'h0 : 21'($urandom);
      wr(OFD_TABLE_POINTER, {11'h0, p});
      exec(16'h0008 | 16'(m) | (16'(m & 1) << 2));
      `CHK(tbl_req, 1'b1)
      `CHK(tbl_wr, 1'(m))
      `CHK(tbl_addr, (m == 3) ? p + 21'd1 : p)
      `CHK(dec.tbl_mode, ofd_tbl_t'(m))
      rd(OFD_TABLE_POINTER, q);
      `CHK(q[20:0], exp_next(p, 2'(m)))
    end
    // Relative branch, both signs
    wr(OFD_CTRL, {28'h0, FMT_BRREL8});
    for (int i = 0; i < 2; i++)
    begin
      r = {1'(i), 7'($urandom)};
      exec({8'he0, r});
      `CHK(dec.branch, {{13{r[7]}}, r})
    end
    // Call, with and without the shadow copy
    wr(OFD_CTRL, {28'h0, FMT_CALL});
    for (int s = 0; s < 2; s++)
    begin
      d12 = 12'($urandom);
      r = 8'($urandom);
      rd(OFD_SHADOW, q);
      wr(OFD_WORD1, {16'h0, 4'hf, d12});
      exec({7'b1110110, 1'(s), r});
      `CHK(dec.branch, {1'b0, d12, r})
      `CHK(dec.fast, 1'(s))
      rd(OFD_SHADOW, q2);
      if (s == 1)
        `CHK(q2[11:8], bank)
      else
        `CHK(q2, q)
    end
    // Literal
    wr(OFD_CTRL, {28'h0, FMT_LIT});
    r = 8'($urandom);
    exec({8'h0e, r});
    `CHK(dec.literal, {12'h0, r})
    // Pointer load into slot two, then an indexed move riding on it
    wr(OFD_CTRL, {28'h0, FMT_LDPTR});
    d12 = 12'($urandom);
    wr(OFD_WORD1, {16'h0, 8'hf0, d12[7:0]});
    exec({8'hee, 4'h2, d12[11:8]});
    `CHK(dec.ptr_sel, 2'h2)
    `CHK(dec.literal, {8'h0, d12})
    rd(OFD_PTR0 + 8'h08, q);
    `CHK(q[11:0], d12)
    wr(OFD_CTRL, {28'h0, FMT_INDEX});
    w = {9'h1d0, 7'($urandom)};
    wr(OFD_WORD1, {16'h0, 9'h1e0, r[6:0]});
    exec(w);
    `CHK(dec.src_addr, d12 + {5'h0, w[6:0]})
    `CHK(dec.dst_addr, d12 + {5'h0, r[6:0]})
    // Product bytes are separate registers
    wr(OFD_PRODUCT_LOW_BYTE, {24'h0, r});
    wr(OFD_PRODUCT_HIGH_BYTE, {24'h0, ~r});
    rd(OFD_PRODUCT_LOW_BYTE, q);
    rd(OFD_PRODUCT_HIGH_BYTE, q2);
    `CHK({q2[7:0], q[7:0]}, {~r, r})
    // Flag updates touch only masked flags
    rd(OFD_STATUS, q);
    fl = q[4:0];
    for (int i = 0; i < 4; i++)
    begin
      m5 = (i == 0) ? 5'h00 : 5'($urandom);
      r = 8'($urandom);
      wr(OFD_FLAGUPD, {19'h0, m5, 3'h0, r[4:0]});
      fl = (fl & ~m5) | (r[4:0] & m5);
      rd(OFD_STATUS, q);
      `CHK(q[4:0], fl)
    end
    // Unmapped place, then a read stalled behind a write
    wr(8'h60, 32'hffffffff);
    rd(8'h60, q);
    `CHK(q, 32'h0)
    wr_rd(OFD_BANK, 32'h0000000a, q);
    `CHK(q[3:0], 4'ha)
    `CHK(hresp, 1'b0)
    results();
  end
endmodule : test_operand_field_decoder
